/* File: verilog/flash_cmd_map.vh */
// Purpose: constants of the external flash command controller
// Assumes: unlock addresses and codes of the usual parallel flash command set
// Notes: all timing counts are cycles of sys_clk (20 MHz, 50 ns)
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

`define CLK_PERIOD_NS     50
// bus cycle phase lengths in ns and derived cycle counts (rounded up)
`define T_SETUP_NS        50
`define T_PULSE_NS        50
`define T_ACCESS_NS       100
`define T_RECOVER_NS      50
`define SETUP_CYC   ((`T_SETUP_NS   + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYC   ((`T_PULSE_NS   + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC  ((`T_ACCESS_NS  + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// unlock cycles
`define UNLOCK1_ADDR      22'h000555
`define UNLOCK2_ADDR      22'h0002AA
`define UNLOCK1_DATA      8'hAA
`define UNLOCK2_DATA      8'h55

// command codes
`define CMD_PROGRAM       8'hA0
`define CMD_FAST_ENTER    8'h20
`define CMD_FAST_RST1     8'h90
`define CMD_FAST_RST2     8'h00
`define CMD_QUERY         8'h98
`define QUERY_ADDR        22'h000055
`define CMD_READ_RESET    8'hF0
`define CMD_SECURE_ENTER  8'h88
`define CMD_SECURE_EXIT1  8'h90
`define CMD_SECURE_EXIT2  8'h00
`define CMD_PROTECT       8'h60

// protect pattern on A6,A3,A2,A1,A0 and its mask
`define PROT_PAT_MASK     22'h00004F
`define PROT_PAT          22'h000002

// last word address that the secure region overlays
`define SEC_LAST_ADDR     22'h00007F

// user operation codes
`define OP_PROGRAM        4'h0
`define OP_READ           4'h1
`define OP_FAST_ENTER     4'h2
`define OP_FAST_EXIT      4'h3
`define OP_QUERY_ENTER    4'h4
`define OP_READ_RESET     4'h5
`define OP_SECURE_ENTER   4'h6
`define OP_SECURE_EXIT    4'h7
`define OP_PROTECT        4'h8
`define OP_PROT_VERIFY    4'h9

// data polling bit
`define POLL_BIT          7
`endif

/* File: verilog/flash_bus_cycle.v */
// Purpose: one asynchronous flash bus cycle (write or read) on the pins
// Assumes: flash is clockless; phase lengths given in sys_clk cycles
// Notes: chip select goes high between cycles so each read is a fresh access
`timescale 1ns/10ps
`include "flash_cmd_map.vh"
module flash_bus_cycle #(
	parameter AW = 22,
	parameter DW = 16
) (
	// clock and reset
	input  wire          sys_clk,
	input  wire          rst_n,
	// request
	input  wire          go,
	input  wire          is_write,
	input  wire [AW-1:0] addr,
	input  wire [DW-1:0] wdata,
	output reg           done,
	output reg  [DW-1:0] rdata,
	// flash pins
	output reg  [AW-1:0] fl_addr,
	output reg  [DW-1:0] fl_dq_o,
	output reg           fl_dq_oe,
	input  wire [DW-1:0] fl_dq_i,
	output reg           fl_ce_n,
	output reg           fl_oe_n,
	output reg           fl_we_n
);
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_SET  = 4'b0010;
	localparam [3:0] S_ACT  = 4'b0100;
	localparam [3:0] S_REC  = 4'b1000;

	// phase lengths cut to the counter width
	localparam integer SETUP_I   = `SETUP_CYC;
	localparam integer PULSE_I   = `PULSE_CYC;
	localparam integer ACCESS_I  = `ACCESS_CYC;
	localparam integer RECOVER_I = `RECOVER_CYC;
	localparam [3:0]   SETUP_N   = SETUP_I[3:0];
	localparam [3:0]   PULSE_N   = PULSE_I[3:0];
	localparam [3:0]   ACCESS_N  = ACCESS_I[3:0];
	localparam [3:0]   RECOVER_N = RECOVER_I[3:0];

	reg [3:0] state_q;
	reg [3:0] cnt_q;
	reg       wr_q;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= S_IDLE;
			cnt_q    <= 4'h0;
			wr_q     <= 1'b0;
			done     <= 1'b0;
			rdata    <= {DW{1'b0}};
			fl_addr  <= {AW{1'b0}};
			fl_dq_o  <= {DW{1'b0}};
			fl_dq_oe <= 1'b0;
			fl_ce_n  <= 1'b1;
			fl_oe_n  <= 1'b1;
			fl_we_n  <= 1'b1;
		end else begin
			done <= 1'b0;
			case (state_q)
			S_IDLE: if (go) begin
				wr_q     <= is_write;
				fl_addr  <= addr;
				fl_dq_o  <= wdata;
				fl_dq_oe <= is_write;
				fl_ce_n  <= 1'b0;
				cnt_q    <= SETUP_N;
				state_q  <= S_SET;
			end
			S_SET: if (cnt_q == 4'h1) begin
				fl_we_n <= ~wr_q;
				fl_oe_n <= wr_q;
				cnt_q   <= wr_q ? PULSE_N : ACCESS_N;
				state_q <= S_ACT;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
			S_ACT: if (cnt_q == 4'h1) begin
				if (!wr_q)
					rdata <= fl_dq_i;
				fl_we_n <= 1'b1;
				fl_oe_n <= 1'b1;
				fl_ce_n <= 1'b1;
				cnt_q   <= RECOVER_N;
				state_q <= S_REC;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
			S_REC: if (cnt_q == 4'h1) begin
				fl_dq_oe <= 1'b0;
				done     <= 1'b1;
				state_q  <= S_IDLE;
			end else begin
				cnt_q <= cnt_q - 4'h1;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: verilog/flash_mode_ctrl.v */
// Purpose: host controller issuing extended-mode command sequences to a flash
// Assumes: user holds op/addr/data stable while start is taken; one op at a time
// Notes: programs are followed by data polling on data_line_seven until done or POLL_MAX is reached
`timescale 1ns/10ps
`include "flash_cmd_map.vh"
// Operation
// - fast mode programs skip both unlock cycles
// - in fast mode only fast program/reset
// - fast mode reset command returns to reads
// - bank address on first fast cycle
// - fast program: setup write then address/payload
// - query code at bank address enters query
// - read/reset sequence leaves query mode
// - fresh chip select before secure/array reads
// - secure exit carries bank address cycle three
// - secure mode allows program/protect/exit only; the code also allows read and protect verify
// - secure program uses ordinary program sequence
// - no program suspend during secure program
// - protect: 60h, pattern address, 60h again
module flash_mode_ctrl #(
	parameter AW       = 22,
	parameter DW       = 16,
	parameter POLL_MAX = 16'hFFFF
) (
	// clock and reset
	input  wire          sys_clk,
	input  wire          rst_n,
	// user command port
	input  wire          start,
	input  wire [3:0]    op,
	input  wire [AW-1:0] op_addr,
	input  wire [DW-1:0] op_data,
	output reg           busy,
	output reg           op_done,
	output reg           op_error,
	output reg  [DW-1:0] rd_data,
	output reg           fast_active,
	output reg           query_active,
	output reg           secure_active,
	// flash pins
	output wire [AW-1:0] fl_addr,
	output wire [DW-1:0] fl_dq_o,
	output wire          fl_dq_oe,
	input  wire [DW-1:0] fl_dq_i,
	output wire          fl_ce_n,
	output wire          fl_oe_n,
	output wire          fl_we_n
);
	localparam [3:0] S_IDLE = 4'b0001;
	localparam [3:0] S_SEQ  = 4'b0010;
	localparam [3:0] S_POLL = 4'b0100;
	localparam [3:0] S_END  = 4'b1000;

	reg [3:0]    state_q;
	reg [3:0]    op_q;
	reg [AW-1:0] addr_q;
	reg [DW-1:0] data_q;
	reg [2:0]    step_q;
	reg [15:0]   poll_q;
	reg          go_q;
	reg          cyc_wr;
	reg [AW-1:0] cyc_addr;
	reg [DW-1:0] cyc_data;
	reg [2:0]    last_step;
	reg          prot_q;
	wire         cyc_done;
	wire [DW-1:0] cyc_rdata;

	// bank select bits above the sector offset
	wire [AW-1:0] bank_base = {addr_q[AW-1:AW-3], {(AW-3){1'b0}}};

	// legality of an operation given the current mode
	function op_legal;
		input [3:0] o;
		input       fm;
		input       sm;
		begin
			if (fm)
				op_legal = (o == `OP_PROGRAM) || (o == `OP_FAST_EXIT);
			else if (sm)
				op_legal = (o == `OP_PROGRAM) || (o == `OP_PROTECT) ||
					(o == `OP_SECURE_EXIT) || (o == `OP_READ) ||
					(o == `OP_PROT_VERIFY);
			else
				op_legal = (o != `OP_FAST_EXIT) && (o != `OP_SECURE_EXIT) &&
					(o != `OP_PROTECT) && (o != `OP_PROT_VERIFY);
		end
	endfunction

	// word addresses covered by the secure region
	function sec_hit;
		input [AW-1:0] a;
		begin
			sec_hit = (a <= `SEC_LAST_ADDR);
		end
	endfunction

	// program into a region already read back as locked is refused
	wire         locked_hit = secure_active && prot_q && (op == `OP_PROGRAM) &&
		sec_hit(op_addr);

	// cycle table: which write or read each step issues
	always @* begin
		cyc_wr    = 1'b1;
		cyc_addr  = `UNLOCK1_ADDR;
		cyc_data  = {{(DW-8){1'b0}}, `UNLOCK1_DATA};
		last_step = 3'd2;
		if (step_q == 3'd1) begin
			cyc_addr = `UNLOCK2_ADDR;
			cyc_data = {{(DW-8){1'b0}}, `UNLOCK2_DATA};
		end
		case (op_q)
		`OP_PROGRAM: begin
			if (fast_active) begin
				last_step = 3'd1;
				cyc_addr  = (step_q == 3'd0) ? bank_base : addr_q;
				cyc_data  = (step_q == 3'd0) ? {{(DW-8){1'b0}}, `CMD_PROGRAM} : data_q;
			end else begin
				last_step = 3'd3;
				if (step_q == 3'd2) begin
					cyc_addr = `UNLOCK1_ADDR;
					cyc_data = {{(DW-8){1'b0}}, `CMD_PROGRAM};
				end else if (step_q == 3'd3) begin
					cyc_addr = addr_q;
					cyc_data = data_q;
				end
			end
		end
		`OP_READ: begin
			last_step = 3'd0;
			cyc_wr    = 1'b0;
			cyc_addr  = addr_q;
			cyc_data  = {DW{1'b0}};
		end
		`OP_FAST_ENTER, `OP_SECURE_ENTER, `OP_READ_RESET: begin
			if (step_q == 3'd2) begin
				cyc_addr = (op_q == `OP_FAST_ENTER) ? `UNLOCK1_ADDR | bank_base :
					`UNLOCK1_ADDR;
				cyc_data = {{(DW-8){1'b0}},
					(op_q == `OP_FAST_ENTER) ? `CMD_FAST_ENTER :
					(op_q == `OP_SECURE_ENTER) ? `CMD_SECURE_ENTER :
					`CMD_READ_RESET};
			end
		end
		`OP_FAST_EXIT: begin
			last_step = 3'd1;
			cyc_addr  = bank_base;
			cyc_data  = {{(DW-8){1'b0}},
				(step_q == 3'd0) ? `CMD_FAST_RST1 : `CMD_FAST_RST2};
		end
		`OP_QUERY_ENTER: begin
			last_step = 3'd0;
			cyc_addr  = `QUERY_ADDR | bank_base;
			cyc_data  = {{(DW-8){1'b0}}, `CMD_QUERY};
		end
		`OP_SECURE_EXIT: begin
			last_step = 3'd3;
			if (step_q == 3'd2) begin
				cyc_addr = `UNLOCK1_ADDR | bank_base;
				cyc_data = {{(DW-8){1'b0}}, `CMD_SECURE_EXIT1};
			end else if (step_q == 3'd3) begin
				cyc_addr = bank_base;
				cyc_data = {{(DW-8){1'b0}}, `CMD_SECURE_EXIT2};
			end
		end
		`OP_PROTECT: begin
			last_step = 3'd1;
			cyc_addr  = (addr_q & ~`PROT_PAT_MASK) | `PROT_PAT;
			cyc_data  = {{(DW-8){1'b0}}, `CMD_PROTECT};
		end
		`OP_PROT_VERIFY: begin
			last_step = 3'd0;
			cyc_wr    = 1'b0;
			cyc_addr  = (addr_q & ~`PROT_PAT_MASK) | `PROT_PAT;
			cyc_data  = {DW{1'b0}};
		end
		default: begin
			last_step = 3'd0;
			cyc_wr    = 1'b0;
			cyc_addr  = addr_q;
		end
		endcase
		// status polling reads back the program target
		if (state_q == S_POLL) begin
			cyc_wr   = 1'b0;
			cyc_addr = addr_q;
			cyc_data = {DW{1'b0}};
		end
	end

	flash_bus_cycle #(
		.AW(AW),
		.DW(DW)
	) u_cycle (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.go       (go_q),
		.is_write (cyc_wr),
		.addr     (cyc_addr),
		.wdata    (cyc_data),
		.done     (cyc_done),
		.rdata    (cyc_rdata),
		.fl_addr  (fl_addr),
		.fl_dq_o  (fl_dq_o),
		.fl_dq_oe (fl_dq_oe),
		.fl_dq_i  (fl_dq_i),
		.fl_ce_n  (fl_ce_n),
		.fl_oe_n  (fl_oe_n),
		.fl_we_n  (fl_we_n)
	);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q       <= S_IDLE;
			op_q          <= 4'h0;
			addr_q        <= {AW{1'b0}};
			data_q        <= {DW{1'b0}};
			step_q        <= 3'd0;
			poll_q        <= 16'h0000;
			go_q          <= 1'b0;
			busy          <= 1'b0;
			op_done       <= 1'b0;
			op_error      <= 1'b0;
			rd_data       <= {DW{1'b0}};
			fast_active   <= 1'b0;
			query_active  <= 1'b0;
			secure_active <= 1'b0;
			prot_q        <= 1'b0;
		end else begin
			go_q    <= 1'b0;
			op_done <= 1'b0;
			case (state_q)
			S_IDLE: if (start) begin
				op_q     <= op;
				addr_q   <= op_addr;
				data_q   <= op_data;
				step_q   <= 3'd0;
				busy     <= 1'b1;
				op_error <= 1'b0;
				if (op_legal(op, fast_active, secure_active) && !locked_hit) begin
					go_q    <= 1'b1;
					state_q <= S_SEQ;
				end else begin
					op_error <= 1'b1;
					state_q  <= S_END;
				end
			end
			S_SEQ: if (cyc_done) begin
				if (step_q != last_step) begin
					step_q <= step_q + 3'd1;
					go_q   <= 1'b1;
				end else if (op_q == `OP_PROGRAM) begin
					poll_q  <= 16'h0000;
					go_q    <= 1'b1;
					state_q <= S_POLL;
				end else begin
					if (!cyc_wr)
						rd_data <= cyc_rdata;
					// verify bit zero set: region locked until reset
					if (op_q == `OP_PROT_VERIFY && cyc_rdata[0])
						prot_q <= 1'b1;
					case (op_q)
					`OP_FAST_ENTER:   fast_active   <= 1'b1;
					`OP_FAST_EXIT:    fast_active   <= 1'b0;
					`OP_QUERY_ENTER:  query_active  <= 1'b1;
					`OP_READ_RESET:   query_active  <= 1'b0;
					`OP_SECURE_ENTER: secure_active <= 1'b1;
					`OP_SECURE_EXIT:  secure_active <= 1'b0;
					default: ;
					endcase
					state_q <= S_END;
				end
			end
			S_POLL: if (cyc_done) begin
				poll_q <= poll_q + 16'h0001;
				if (cyc_rdata[`POLL_BIT] == data_q[`POLL_BIT]) begin
					rd_data <= cyc_rdata;
					state_q <= S_END;
				end else if (poll_q == POLL_MAX) begin
					op_error <= 1'b1;
					state_q  <= S_END;
				end else begin
					go_q <= 1'b1;
				end
			end
			S_END: begin
				busy    <= 1'b0;
				op_done <= 1'b1;
				state_q <= S_IDLE;
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule

/* File: sim/flash_ctrl_properties.sv */
// Purpose: port checks of the flash command controller
// Assumes: one operation at a time
// Notes: bound to flash_mode_ctrl
`timescale 1ns/10ps
`include "flash_cmd_map.vh"
module flash_ctrl_properties (
	// clock and reset
	input wire        sys_clk,
	input wire        rst_n,
	// user port
	input wire        start,
	input wire [3:0]  op,
	input wire        busy,
	input wire        op_done,
	input wire        op_error,
	input wire        fast_active,
	input wire        secure_active,
	// flash pins
	input wire [21:0] fl_addr,
	input wire        fl_dq_oe,
	input wire        fl_ce_n,
	input wire        fl_oe_n,
	input wire        fl_we_n
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_take; start && !busy |=> busy; endproperty
	a_take: assert property (p_take) else $error("start not taken");
	property p_pulse; op_done |=> !op_done && !busy; endproperty
	a_pulse: assert property (p_pulse) else $error("done not a pulse");
	property p_wr; !fl_we_n |-> fl_oe_n && fl_dq_oe && !fl_ce_n; endproperty
	a_wr: assert property (p_wr) else $error("bad write cycle");
	property p_rd; !fl_oe_n |-> !fl_dq_oe && !fl_ce_n && fl_we_n; endproperty
	a_rd: assert property (p_rd) else $error("bad read cycle");
	property p_fresh; $rose(fl_oe_n) |-> fl_ce_n; endproperty
	a_fresh: assert property (p_fresh) else $error("no fresh select");
	property p_addr; !fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_excl; fast_active |-> !secure_active; endproperty
	a_excl: assert property (p_excl) else $error("two modes");
	property p_refuse;
		start && !busy && fast_active && op == `OP_READ |-> ##[1:3] (op_done && op_error);
	endproperty
	a_refuse: assert property (p_refuse) else $error("not refused");
	c_fast: cover property (fast_active && op_done);
	c_sec: cover property (secure_active && op_done && !op_error);
	c_err: cover property (op_done && op_error);
endmodule
bind flash_mode_ctrl flash_ctrl_properties u_flash_ctrl_properties (
	.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .op(op), .busy(busy),
	.op_done(op_done), .op_error(op_error), .fast_active(fast_active),
	.secure_active(secure_active), .fl_addr(fl_addr), .fl_dq_oe(fl_dq_oe),
	.fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n));

/* File: sim/flash_model.sv */
// Purpose: behavioural flash device with extended modes
// Assumes: writes latched on rising write strobe
// Notes: small array, index by low address bits
`timescale 1ns/10ps
`include "flash_cmd_map.vh"
module flash_model (
	// flash pins
	input wire [21:0]   fl_addr,
	input wire [15:0]   fl_dq_o,
	input wire          fl_ce_n,
	input wire          fl_oe_n,
	input wire          fl_we_n,
	output logic [15:0] fl_dq_i
);
	logic [15:0] m [0:15];
	logic [15:0] s [0:15];
	logic [15:0] q = 0, last = 0;
	logic [2:0]  u = 0, qb = 0;
	logic        pg = 0, fst = 0, qry = 0, sec = 0, prot = 0, p60 = 0, ex = 0;
	int          bz = 0;
	wire [7:0]   d = fl_dq_o[7:0];
	wire         pat = (fl_addr & `PROT_PAT_MASK) == `PROT_PAT;
	wire         in_sec = sec && fl_addr < 22'h000080;
	always @(posedge fl_we_n) begin
		if (pg) begin
			pg = 0;
			last = fl_dq_o;
			bz = 2;
			if (!in_sec) m[fl_addr[3:0]] = fl_dq_o;
			else if (!prot) s[fl_addr[3:0]] = fl_dq_o;
		end else if (fst) begin
			pg = d == `CMD_PROGRAM;
			if (ex && d == `CMD_FAST_RST2) fst = 0;
			ex = d == `CMD_FAST_RST1;
		end else if (ex) begin
			ex = 0;
			if (d == `CMD_SECURE_EXIT2) sec = 0;
		end else if (sec && d == `CMD_PROTECT) begin
			if (p60 && pat) prot = 1;
			p60 = !p60;
		end else if (u == 2) begin
			u = 0;
			case (d)
				`CMD_PROGRAM: pg = 1;
				`CMD_FAST_ENTER: fst = 1;
				`CMD_SECURE_ENTER: sec = 1;
				`CMD_SECURE_EXIT1: ex = 1;
				`CMD_READ_RESET: qry = 0;
				default: u = 0;
			endcase
		end else if (d == `UNLOCK1_DATA && fl_addr[11:0] == 12'h555) u = 1;
		else if (u == 1 && d == `UNLOCK2_DATA) u = 2;
		else if (d == `CMD_QUERY) begin
			qry = 1;
			qb = fl_addr[21:19];
		end else u = 0;
	end
	always @(negedge fl_oe_n) begin
		if (bz > 0) begin
			bz--;
			q = last ^ 16'h0080;
		end else if (qry && fl_addr[21:19] == qb) q = 16'h0051;
		else if (sec && pat) q = {15'h0000, prot};
		else if (in_sec) q = s[fl_addr[3:0]];
		else q = m[fl_addr[3:0]];
	end
	assign fl_dq_i = (!fl_oe_n && !fl_ce_n) ? q : ~q;
endmodule

/* File: sim/flash_mode_ctrl_bench.sv */
// Purpose: self-checking bench of flash_mode_ctrl
// Assumes: poll limit shortened to 8
// Notes: nw counts write strobes
`timescale 1ns/10ps
`include "flash_cmd_map.vh"
`define check(a,b) begin check_count++; if ((a) !== (b)) begin n_errors++; $display("Error %0t: got %h want %h", $time, a, b); end end
module flash_mode_ctrl_bench;
	logic        sys_clk = 0, rst_n = 0, start = 0;
	logic [3:0]  op = 0;
	logic [21:0] op_addr = 0;
	logic [15:0] op_data = 0;
	wire         busy, op_done, op_error, fast_active, query_active, secure_active;
	wire [15:0]  rd_data, fl_dq_o, fl_dq_i;
	wire [21:0]  fl_addr;
	wire         fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
	int          n_errors = 0, check_count = 0, nw = 0;
	initial forever #25 sys_clk = ~sys_clk;
	always @(negedge fl_we_n) nw++;
	flash_mode_ctrl #(.POLL_MAX(16'h0008)) u_flash_mode_ctrl (
		.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .op(op), .op_addr(op_addr),
		.op_data(op_data), .busy(busy), .op_done(op_done), .op_error(op_error),
		.rd_data(rd_data), .fast_active(fast_active), .query_active(query_active),
		.secure_active(secure_active), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
		.fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
		.fl_we_n(fl_we_n));
	flash_model u_flash_model (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_i(fl_dq_i));
	task tally_and_finish;
		if (n_errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task run(input [3:0] o, input [21:0] a, input [15:0] d);
		int i;
		@(posedge sys_clk);
		start <= 1'b1;
		op <= o;
		op_addr <= a;
		op_data <= d;
		@(posedge sys_clk);
		start <= 1'b0;
		for (i = 0; i < 500 && op_done !== 1'b1; i++) @(negedge sys_clk);
		if (i == 500) begin
			n_errors++;
			tally_and_finish;
		end
	endtask
	task t_fast;
		nw = 0;
		run(`OP_PROGRAM, 22'h000003, 16'h1234);
		`check(nw, 4)
		`check(rd_data, 16'h1234)
		run(`OP_FAST_ENTER, 22'h000000, 16'h0000);
		`check(fast_active, 1'b1)
		nw = 0;
		run(`OP_PROGRAM, 22'h000004, 16'h5A5A);
		`check(nw, 2)
		`check(rd_data, 16'h5A5A)
		`check(op_error, 1'b0)
		run(`OP_READ, 22'h000004, 16'h0000);
		`check(op_error, 1'b1)
		run(`OP_FAST_EXIT, 22'h000000, 16'h0000);
		`check(fast_active, 1'b0)
		run(`OP_READ, 22'h000004, 16'h0000);
		`check(rd_data, 16'h5A5A)
	endtask
	task t_query;
		run(`OP_QUERY_ENTER, 22'h000000, 16'h0000);
		`check(query_active, 1'b1)
		run(`OP_READ, 22'h000010, 16'h0000);
		`check(rd_data, 16'h0051)
		run(`OP_READ, 22'h080003, 16'h0000);
		`check(rd_data, 16'h1234)
		run(`OP_READ_RESET, 22'h000000, 16'h0000);
		`check(query_active, 1'b0)
	endtask
	task t_secure;
		run(`OP_SECURE_EXIT, 22'h000000, 16'h0000);
		`check(op_error, 1'b1)
		run(`OP_PROGRAM, 22'h000010, 16'hBEEF);
		run(`OP_SECURE_ENTER, 22'h000000, 16'h0000);
		`check(secure_active, 1'b1)
		run(`OP_PROGRAM, 22'h000010, 16'hC0DE);
		run(`OP_READ, 22'h000010, 16'h0000);
		`check(rd_data, 16'hC0DE)
		run(`OP_READ, 22'h080003, 16'h0000);
		`check(rd_data, 16'h1234)
		run(`OP_PROT_VERIFY, 22'h000002, 16'h0000);
		`check(rd_data[0], 1'b0)
		run(`OP_PROTECT, 22'h000002, 16'h0000);
		run(`OP_PROGRAM, 22'h000010, 16'h0000);
		`check(op_error, 1'b1)
		run(`OP_PROT_VERIFY, 22'h000002, 16'h0000);
		`check(rd_data[0], 1'b1)
		nw = 0;
		run(`OP_PROGRAM, 22'h000010, 16'h0000);
		`check(op_error, 1'b1)
		`check(nw, 0)
		run(`OP_READ, 22'h000010, 16'h0000);
		`check(rd_data, 16'hC0DE)
		run(`OP_SECURE_EXIT, 22'h000000, 16'h0000);
		run(`OP_READ, 22'h000010, 16'h0000);
		`check(rd_data, 16'hBEEF)
		run(`OP_SECURE_ENTER, 22'h000000, 16'h0000);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		@(negedge sys_clk);
		`check(secure_active, 1'b0)
	endtask
	initial begin
		@(posedge sys_clk);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		t_fast;
		t_query;
		t_secure;
		tally_and_finish;
	end
endmodule
